/* verilog/chg_cfg.svh */
// Purpose: Constants of the charger SMBus control and protection block
// Assumes: 10 MHz system clock, synchronous active-high reset
// Notes: Rule summary follows
`ifndef CHG_CFG_SVH
`define CHG_CFG_SVH

`define CHG_CLK_HZ 10000000
`define CHG_SMB_ADDR 7'h09

`define CHG_CMD_OPT 8'h12
`define CHG_CMD_CC 8'h14
`define CHG_CMD_CV 8'h15
`define CHG_CMD_IC 8'h3f
`define CHG_CMD_MAKER 8'hfe
`define CHG_CMD_PART 8'hff

`define CHG_OPT_RST 16'hf902
`define CHG_CC_RST 16'h0000
`define CHG_CV_RST 16'h0000
`define CHG_IC_RST 16'h1000
`define CHG_OPT_WMASK 16'hffef
`define CHG_CC_MASK 16'h1fc0
`define CHG_CV_MASK 16'h7ff0
`define CHG_IC_MASK 16'h1f80

`define CHG_OPT_DGL 15
`define CHG_OPT_WD_HI 14
`define CHG_OPT_WD_LO 13
`define CHG_OPT_FUP 10
`define CHG_OPT_FEN 9
`define CHG_OPT_HSEN 8
`define CHG_OPT_LSSEL 7
`define CHG_OPT_LEARN 6
`define CHG_OPT_CURRENT_MONITOR_OUTPUT 5
`define CHG_OPT_ADPT 4

`define CHG_WD_OFF 2'h0
`define CHG_WD_SHORT 2'h1
`define CHG_WD_MID 2'h2
`define CHG_WD_SHORT_S 44
`define CHG_WD_MID_S 88
`define CHG_WD_LONG_S 175
`define CHG_WD_SHORT_CYC (`CHG_WD_SHORT_S * `CHG_CLK_HZ)
`define CHG_WD_MID_CYC (`CHG_WD_MID_S * `CHG_CLK_HZ)
`define CHG_WD_LONG_CYC (`CHG_WD_LONG_S * `CHG_CLK_HZ)

`define CHG_DG_SHORT_MS 150
`define CHG_DG_LONG_MS 1300
`define CHG_DG_SHORT_CYC (`CHG_DG_SHORT_MS * (`CHG_CLK_HZ / 1000))
`define CHG_DG_LONG_CYC (`CHG_DG_LONG_MS * (`CHG_CLK_HZ / 1000))

`define CHG_BLANK_NS 200
`define CHG_BLANK_CYC ((`CHG_BLANK_NS * (`CHG_CLK_HZ / 1000000) + 999) / 1000)
`define CHG_SOFT_US 1000
`define CHG_SOFT_CYC (`CHG_SOFT_US * (`CHG_CLK_HZ / 1000000))
`define CHG_SHORT_EVENTS 7

`endif

/* verilog/chg_pkg.sv */
// Purpose: Types shared by the charger control block
// Assumes: Constants live in chg_cfg.svh
// Notes: Sense flags come from analog comparators already clocked
package chg_pkg;

	typedef enum logic [1:0] {TH_RUN, TH_OFF, TH_SOFT} chg_therm_t;

	typedef enum logic [2:0] {SM_IDLE, SM_RX, SM_ACK, SM_TX, SM_TXACK, SM_SKIP} chg_smb_t;

	typedef struct packed {
		logic tj_above_155;
		logic tj_below_135;
		logic supply_supply_undervoltage_lockout;
		logic adet_above_0v6;
		logic adet_above_2v4;
		logic adapter_good_raw;
		logic hs_switch_on;
		logic ls_switch_on;
		logic hs_short_cmp;
		logic ls_short_cmp;
		logic learn_depleted;
	} chg_sense_t;

	typedef struct packed {
		logic converter_on;
		logic soft_start;
		logic freq_adjust_en;
		logic freq_raise;
		logic hs_short_detect_en;
		logic ls_thresh_high;
		logic current_monitor_output_charge_sel;
		logic adapter_switch_on;
		logic reverse_block_switch_on;
		logic battery_switch_on;
		logic adapter_good;
		logic short_latched;
		logic charge_suspended;
		logic thermal_shutdown;
	} chg_drive_t;

endpackage

/* verilog/chg_short_mon.sv */
// Purpose: One short-circuit event counter with turn-on blanking
// Assumes: sw_on follows the gate drive of the watched switch
// Notes: Trip stays set until clr; clr has priority over counting
`include "chg_cfg.svh"
module chg_short_mon #(
	parameter int BLANK_CYC = `CHG_BLANK_CYC,
	parameter int EVENTS = `CHG_SHORT_EVENTS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clr,
	input wire logic enable,
	input wire logic sw_on,
	input wire logic cmp,
	output logic tripped
);
	localparam int BW = $clog2(BLANK_CYC + 1);
	localparam int EW = $clog2(EVENTS + 1);

	if (BLANK_CYC < 1 || EVENTS < 1) begin : g_bad_param
		$error("chg_short_mon: BLANK_CYC and EVENTS must be at least one");
	end

	logic [BW-1:0] bcnt;
	logic [EW-1:0] ecnt;
	wire sample_now = sw_on && (bcnt == BW'(BLANK_CYC - 1));
	wire short_event = sample_now && cmp && enable;

	// One sample per on-period, so turn-on ringing never counts
	always_ff @(posedge clk_sys) begin
		if (rst || !sw_on) begin
			bcnt <= '0;
		end else if (bcnt != BW'(BLANK_CYC)) begin
			bcnt <= bcnt + BW'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || clr) begin
			ecnt <= '0;
			tripped <= 1'b0;
		end else if (short_event && !tripped) begin
			ecnt <= ecnt + EW'(1);
			tripped <= (ecnt == EW'(EVENTS - 1));
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_BLANK_SAMPLE: assert property (ecnt != $past(ecnt) && !$past(clr) |-> $past(sw_on)
		&& $past(bcnt) == BW'(BLANK_CYC - 1))
		else $error("short event counted outside the blanking sample point");
	AST_TRIP_AT_COUNT: assert property ($rose(tripped) |-> $past(ecnt) == EW'(EVENTS - 1) && $past(cmp))
		else $error("trip without the full event count");
endmodule

/* verilog/chg_ctrl.sv */
// Purpose: SMBus register bank, watchdog, deglitch, short latch and thermal sequencing of a charger
// Assumes: SMBus pins and analog flags are synchronous to clk_sys
// Notes: SDA is open drain; smb_sda_oe_n low pulls the line low
`include "chg_cfg.svh"
module chg_ctrl #(
	parameter logic [6:0] SLAVE_ADDR = `CHG_SMB_ADDR,
	parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
	parameter logic [15:0] PART_CODE = 16'h005a, // Arbitrary value
	parameter int WD_SHORT_CYC = `CHG_WD_SHORT_CYC,
	parameter int WD_MID_CYC = `CHG_WD_MID_CYC,
	parameter int WD_LONG_CYC = `CHG_WD_LONG_CYC,
	parameter int DG_SHORT_CYC = `CHG_DG_SHORT_CYC,
	parameter int DG_LONG_CYC = `CHG_DG_LONG_CYC,
	parameter int SOFT_CYC = `CHG_SOFT_CYC,
	parameter int BLANK_CYC = `CHG_BLANK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic smb_scl,
	input wire logic smb_sda_in,
	output logic smb_sda_out,
	output logic smb_sda_oe_n,
	input wire chg_pkg::chg_sense_t sense,
	output chg_pkg::chg_drive_t drive
);
	if (WD_SHORT_CYC < 2 || WD_MID_CYC < 2 || WD_LONG_CYC < 2 || DG_SHORT_CYC < 2 || DG_LONG_CYC < 2
		|| SOFT_CYC < 1 || BLANK_CYC < 1) begin : g_bad_param
		$error("chg_ctrl: timing parameters out of range");
	end

	chg_pkg::chg_smb_t sm_state;
	chg_pkg::chg_therm_t th_state;
	chg_pkg::chg_drive_t next_drive;
	logic scl_q, sda_q, rw, tx_hi, host_ack, wr_pulse;
	logic [7:0] shreg, cmd, data_lo;
	logic [3:0] bitcnt;
	logic [1:0] phase;
	logic [15:0] tx_word, wr_word, rd_word, opt_rd;
	logic [15:0] opt, cc, cv, ic;
	logic [31:0] wd_cnt, wd_limit, dg_cnt, dg_limit, soft_cnt;
	logic wd_susp, ac_good, ac_off_seen;
	logic [1:0] mon_sw, mon_cmp, mon_en, mon_trip;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Bus conditions
	wire bus_ok = !sense.supply_supply_undervoltage_lockout && sense.adet_above_0v6;
	wire bus_start = scl_q && smb_scl && sda_q && !smb_sda_in;
	wire bus_stop = scl_q && smb_scl && !sda_q && smb_sda_in;
	wire scl_rise = smb_scl && !scl_q;
	wire scl_fall = !smb_scl && scl_q;
	wire [7:0] tx_byte = tx_hi ? tx_word[15:8] : tx_word[7:0];
	wire tx_bit = tx_byte[3'h7 - bitcnt[2:0]];

	// Command decode: only a complete Write-Word commits
	wire wr_opt = wr_pulse && (cmd == `CHG_CMD_OPT);
	wire wr_cc = wr_pulse && (cmd == `CHG_CMD_CC);
	wire wr_cv = wr_pulse && (cmd == `CHG_CMD_CV);
	wire wr_ic = wr_pulse && (cmd == `CHG_CMD_IC);

	assign opt_rd = {opt[15:`CHG_OPT_ADPT+1], sense.adet_above_2v4, opt[`CHG_OPT_ADPT-1:0]};
	assign rd_word = (cmd == `CHG_CMD_OPT) ? opt_rd :
		(cmd == `CHG_CMD_CC) ? cc :
		(cmd == `CHG_CMD_CV) ? cv :
		(cmd == `CHG_CMD_IC) ? ic :
		(cmd == `CHG_CMD_MAKER) ? MAKER_CODE :
		(cmd == `CHG_CMD_PART) ? PART_CODE : 16'h0000;

	assign smb_sda_out = 1'b0;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= smb_scl;
			sda_q <= smb_sda_in;
		end
	end

	// Write-Word: addr+W, cmd, low byte, high byte. Read-Word: addr+W, cmd, restart, addr+R, low, high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sm_state <= chg_pkg::SM_IDLE;
			smb_sda_oe_n <= 1'b1;
			shreg <= 8'h00;
			cmd <= 8'h00;
			data_lo <= 8'h00;
			bitcnt <= 4'h0;
			phase <= 2'h0;
			rw <= 1'b0;
			tx_word <= 16'h0000;
			tx_hi <= 1'b0;
			host_ack <= 1'b0;
			wr_word <= 16'h0000;
			wr_pulse <= 1'b0;
		end else begin
			wr_pulse <= 1'b0;
			if (!bus_ok || bus_stop) begin
				sm_state <= chg_pkg::SM_IDLE;
				smb_sda_oe_n <= 1'b1;
			end else if (bus_start) begin
				sm_state <= chg_pkg::SM_RX;
				smb_sda_oe_n <= 1'b1;
				bitcnt <= 4'h0;
				phase <= 2'h0;
			end else begin
				unique case (sm_state)
					chg_pkg::SM_IDLE, chg_pkg::SM_SKIP: begin
					end
					chg_pkg::SM_RX: begin
						if (scl_rise) begin
							shreg <= {shreg[6:0], smb_sda_in};
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							smb_sda_oe_n <= 1'b0;
							sm_state <= chg_pkg::SM_ACK;
							if (phase == 2'h0) begin
								rw <= shreg[0];
								if (shreg[7:1] != SLAVE_ADDR) begin
									smb_sda_oe_n <= 1'b1;
									sm_state <= chg_pkg::SM_SKIP;
								end
							end
							if (phase == 2'h1) begin
								cmd <= shreg;
							end
							if (phase == 2'h2) begin
								data_lo <= shreg;
							end
							if (phase == 2'h3) begin
								wr_word <= {shreg, data_lo};
								wr_pulse <= 1'b1;
							end
						end
					end
					chg_pkg::SM_ACK: begin
						if (scl_fall) begin
							if (rw && phase == 2'h0) begin
								tx_word <= rd_word;
								tx_hi <= 1'b0;
								smb_sda_oe_n <= rd_word[7];
								bitcnt <= 4'h1;
								sm_state <= chg_pkg::SM_TX;
							end else if (phase == 2'h3 || rw) begin
								smb_sda_oe_n <= 1'b1;
								sm_state <= chg_pkg::SM_SKIP;
							end else begin
								smb_sda_oe_n <= 1'b1;
								bitcnt <= 4'h0;
								phase <= phase + 2'h1;
								sm_state <= chg_pkg::SM_RX;
							end
						end
					end
					chg_pkg::SM_TX: begin
						if (scl_fall) begin
							if (bitcnt == 4'h8) begin
								smb_sda_oe_n <= 1'b1;
								sm_state <= chg_pkg::SM_TXACK;
							end else begin
								smb_sda_oe_n <= tx_bit;
								bitcnt <= bitcnt + 4'h1;
							end
						end
					end
					chg_pkg::SM_TXACK: begin
						if (scl_rise) begin
							host_ack <= !smb_sda_in;
						end else if (scl_fall) begin
							if (host_ack && !tx_hi) begin
								tx_hi <= 1'b1;
								smb_sda_oe_n <= tx_word[15];
								bitcnt <= 4'h1;
								sm_state <= chg_pkg::SM_TX;
							end else begin
								sm_state <= chg_pkg::SM_SKIP;
							end
						end
					end
				endcase
			end
		end
	end

	// Register bank; identification words have no storage, so writes to them vanish
	wire learn_done = opt[`CHG_OPT_LEARN] && sense.learn_depleted;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			opt <= `CHG_OPT_RST;
			cc <= `CHG_CC_RST;
			cv <= `CHG_CV_RST;
			ic <= `CHG_IC_RST;
		end else begin
			if (wr_opt) begin
				opt <= wr_word & `CHG_OPT_WMASK;
			end else if (learn_done) begin
				opt[`CHG_OPT_LEARN] <= 1'b0;
			end
			if (wr_cc) begin
				cc <= wr_word & `CHG_CC_MASK;
			end
			if (wr_cv) begin
				cv <= wr_word & `CHG_CV_MASK;
			end
			if (wr_ic) begin
				ic <= wr_word & `CHG_IC_MASK;
			end
		end
	end

	// Watchdog: expiry and a resuming write in one cycle leave charging suspended
	wire [1:0] wd_sel = opt[`CHG_OPT_WD_HI:`CHG_OPT_WD_LO];
	wire wd_en = wd_sel != `CHG_WD_OFF;
	wire wd_touch = wr_cc || wr_cv;
	assign wd_limit = (wd_sel == `CHG_WD_SHORT) ? 32'(WD_SHORT_CYC) :
		(wd_sel == `CHG_WD_MID) ? 32'(WD_MID_CYC) : 32'(WD_LONG_CYC);
	wire wd_expire = wd_en && !wd_susp && (wd_cnt >= wd_limit - 32'h1);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wd_cnt <= 32'h0;
			wd_susp <= 1'b0;
		end else begin
			wd_susp <= wd_expire || (wd_susp && wd_en && !wd_touch);
			if (wd_touch || !wd_en || wd_susp) begin
				wd_cnt <= 32'h0;
			end else begin
				wd_cnt <= wd_cnt + 32'h1;
			end
		end
	end

	// Adapter-good deglitch; the long time is only honoured once the adapter switch has opened
	assign dg_limit = (ac_off_seen && opt[`CHG_OPT_DGL]) ? 32'(DG_LONG_CYC) : 32'(DG_SHORT_CYC);

	always_ff @(posedge clk_sys) begin
		if (rst || !sense.adapter_good_raw) begin
			dg_cnt <= 32'h0;
			ac_good <= 1'b0;
		end else if (!ac_good) begin
			ac_good <= (dg_cnt >= dg_limit - 32'h1);
			dg_cnt <= dg_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ac_off_seen <= 1'b0;
		end else if (drive.adapter_switch_on && !next_drive.adapter_switch_on) begin
			ac_off_seen <= 1'b1;
		end
	end

	// Thermal shutdown with restart through soft start
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			th_state <= chg_pkg::TH_RUN;
			soft_cnt <= 32'h0;
		end else begin
			unique case (th_state)
				chg_pkg::TH_RUN: begin
					if (sense.tj_above_155) begin
						th_state <= chg_pkg::TH_OFF;
					end
				end
				chg_pkg::TH_OFF: begin
					soft_cnt <= 32'h0;
					if (sense.tj_below_135 && !sense.tj_above_155) begin
						th_state <= chg_pkg::TH_SOFT;
					end
				end
				chg_pkg::TH_SOFT: begin
					soft_cnt <= soft_cnt + 32'h1;
					if (sense.tj_above_155) begin
						th_state <= chg_pkg::TH_OFF;
					end else if (soft_cnt == 32'(SOFT_CYC - 1)) begin
						th_state <= chg_pkg::TH_RUN;
					end
				end
			endcase
		end
	end

	// Short monitors: low side at index 0, high side at index 1
	wire short_clr = sense.supply_supply_undervoltage_lockout || !sense.adet_above_0v6;
	wire short_latched = |mon_trip;
	assign mon_sw = {sense.hs_switch_on, sense.ls_switch_on};
	assign mon_cmp = {sense.hs_short_cmp, sense.ls_short_cmp};
	assign mon_en = {opt[`CHG_OPT_HSEN], 1'b1};

	for (genvar i = 0; i < 2; i++) begin : g_mon
		chg_short_mon #(
			.BLANK_CYC(BLANK_CYC),
			.EVENTS(`CHG_SHORT_EVENTS)
		) u_mon (
			.clk_sys(clk_sys),
			.rst(rst),
			.clr(short_clr),
			.enable(mon_en[i]),
			.sw_on(mon_sw[i]),
			.cmp(mon_cmp[i]),
			.tripped(mon_trip[i])
		);
	end

	always_comb begin
		next_drive = '0;
		next_drive.converter_on = (th_state != chg_pkg::TH_OFF) && !short_latched && !wd_susp && ac_good;
		next_drive.soft_start = th_state == chg_pkg::TH_SOFT;
		next_drive.thermal_shutdown = th_state == chg_pkg::TH_OFF;
		next_drive.freq_adjust_en = opt[`CHG_OPT_FEN];
		next_drive.freq_raise = opt[`CHG_OPT_FEN] && opt[`CHG_OPT_FUP];
		next_drive.hs_short_detect_en = opt[`CHG_OPT_HSEN];
		next_drive.ls_thresh_high = opt[`CHG_OPT_LSSEL];
		next_drive.current_monitor_output_charge_sel = opt[`CHG_OPT_CURRENT_MONITOR_OUTPUT];
		next_drive.adapter_switch_on = ac_good && !short_latched && !opt[`CHG_OPT_LEARN];
		next_drive.reverse_block_switch_on = next_drive.adapter_switch_on;
		next_drive.battery_switch_on = !next_drive.adapter_switch_on;
		next_drive.adapter_good = ac_good;
		next_drive.short_latched = short_latched;
		next_drive.charge_suspended = wd_susp;
	end

	// Battery switch stays closed through reset so the system keeps power
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			drive <= '0;
			drive.battery_switch_on <= 1'b1;
		end else begin
			drive <= next_drive;
		end
	end

	AST_THERMAL_OFF: assert property (sense.tj_above_155 |-> ##2 !drive.converter_on && drive.thermal_shutdown)
		else $error("converter still on after over-temperature");
	AST_FREQ_ENABLE: assert property (wr_opt |-> ##2 drive.freq_adjust_en == $past(wr_word[9], 2))
		else $error("frequency enable does not follow option bit 9");
	AST_FREQ_DIR: assert property (drive.freq_raise |-> drive.freq_adjust_en)
		else $error("frequency raised while adjustment disabled");
	AST_LATCH_SWITCHES: assert property ($rose(drive.short_latched) |-> !drive.adapter_switch_on
		&& !drive.reverse_block_switch_on && drive.battery_switch_on)
		else $error("latch did not open adapter path");
	AST_LATCH_HOLD: assert property (short_latched && !short_clr |=> short_latched)
		else $error("short latch cleared without lockout or adapter loss");
	AST_ID_WRITE: assert property (wr_pulse && cmd >= `CHG_CMD_MAKER |=> $stable(opt) && $stable(cc) && $stable(cv)
		&& $stable(ic))
		else $error("write to identification word changed a register");
	AST_FIRST_DEGLITCH: assert property (!ac_off_seen |-> dg_limit == 32'(DG_SHORT_CYC))
		else $error("long deglitch before adapter switch opened");
	AST_BUS_GATE: assert property (!bus_ok |=> sm_state == chg_pkg::SM_IDLE && smb_sda_oe_n)
		else $error("bus served while supply invalid");
	AST_WD_EXPIRE: assert property (wd_en && !wd_susp && wd_cnt == wd_limit - 32'h1 |=> wd_susp ##1 !drive.converter_on)
		else $error("watchdog expiry did not suspend charging");
	AST_WD_RESUME: assert property (wd_susp && wd_touch && wd_en |=> !wd_susp && wd_cnt == 32'h0)
		else $error("write did not resume charging");
	AST_WD_KEEP: assert property ($rose(wd_susp) |-> $stable(cc) && $stable(cv) && $stable(ic))
		else $error("watchdog expiry changed a register");
	AST_LEARN_CLEAR: assert property (learn_done && !wr_opt |=> !opt[`CHG_OPT_LEARN])
		else $error("learn bit did not clear");

	COV_WRITE_WORD: cover property (wr_pulse);
	COV_WD_EXPIRE: cover property ($rose(wd_susp));
	COV_SHORT_LATCH: cover property ($rose(short_latched));
	COV_THERMAL_RESTART: cover property (th_state == chg_pkg::TH_SOFT ##1 th_state == chg_pkg::TH_RUN);
endmodule

/* verification/chg_host.sv */
// Purpose: Behavioural SMBus host issuing Write-Word and Read-Word transfers
// Assumes: SDA has a pull-up; sda_line is the resolved wire level
// Notes: SCL high phase lasts four clocks, twice the minimum the block needs; SCL low phase lasts six
module chg_host #(
	parameter logic [6:0] ADDR = 7'h09
) (
	input wire logic clk_sys,
	input wire logic sda_line,
	output logic smb_scl,
	output logic host_sda
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		smb_scl = 1'b1;
		host_sda = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
		#10;
	endtask

	// Also serves as repeated start: SDA is raised while SCL is still low
	task automatic start_cond();
		host_sda = 1'b1;
		hold(4);
		smb_scl = 1'b1;
		hold(4);
		host_sda = 1'b0;
		hold(4);
		smb_scl = 1'b0;
		hold(2);
	endtask

	task automatic stop_cond();
		host_sda = 1'b0;
		hold(4);
		smb_scl = 1'b1;
		hold(4);
		host_sda = 1'b1;
		hold(4);
	endtask

	// SDA only moves while SCL is low, so no false start or stop
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
		logic [8:0] tx;
		logic [8:0] rx;
		tx = {d, mack};
		for (int i = 8; i >= 0; i--) begin
			host_sda = tx[i];
			hold(4);
			smb_scl = 1'b1;
			hold(4);
			rx[i] = sda_line;
			smb_scl = 1'b0;
			hold(2);
		end
		r = rx[8:1];
		ack = rx[0];
	endtask

	task automatic write_word(input logic [7:0] cmd, input logic [15:0] data, output logic nack);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		start_cond();
		xfer({ADDR, 1'b0}, 1'b1, r, a0);
		xfer(cmd, 1'b1, r, a1);
		xfer(data[7:0], 1'b1, r, a2);
		xfer(data[15:8], 1'b1, r, a3);
		stop_cond();
		nack = a0 | a1 | a2 | a3;
	endtask

	task automatic read_word(input logic [7:0] cmd, output logic [15:0] data, output logic nack);
		logic [7:0] r;
		logic a0, a1, a2, dummy;
		start_cond();
		xfer({ADDR, 1'b0}, 1'b1, r, a0);
		xfer(cmd, 1'b1, r, a1);
		start_cond();
		xfer({ADDR, 1'b1}, 1'b1, r, a2);
		xfer(8'hff, 1'b0, data[7:0], dummy);
		xfer(8'hff, 1'b1, data[15:8], dummy);
		stop_cond();
		nack = a0 | a1 | a2;
	endtask
endmodule

/* verification/testbench.sv */
// Purpose: Self-checking bench for the charger control block
// Assumes: Shortened watchdog, deglitch and soft-start counts
// Notes: Expected values go in a queue; a monitor compares them in order
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WD_S = 1500;
	localparam int WD_M = 3000;
	localparam int WD_L = 6000;
	localparam int DG_S = 20;
	localparam int DG_L = 60;
	localparam int SOFT = 10;
	localparam logic [15:0] MAKER = 16'h3c5a; // Arbitrary value
	localparam logic [15:0] PART = 16'h0617; // Arbitrary value
	`define CHK(e, g) begin exp_q.push_back(e); got_q.push_back(g); end

	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic smb_scl, host_sda, smb_sda_out, smb_sda_oe_n;
	wire logic sda_line;
	chg_pkg::chg_sense_t sense;
	chg_pkg::chg_drive_t drive, m_ag, m_ss, m_su;
	logic [15:0] exp_q[$];
	logic [15:0] got_q[$];
	logic [15:0] rd, w;
	logic [3:0] b;
	logic nack;
	int mismatches = 0;
	int checks_done = 0;
	int seed = 42;
	int k, per;

	// Open drain with pull-up: low if either party pulls
	assign sda_line = host_sda & (smb_sda_oe_n | smb_sda_out);

	chg_ctrl #(.MAKER_CODE(MAKER), .PART_CODE(PART), .WD_SHORT_CYC(WD_S), .WD_MID_CYC(WD_M), .WD_LONG_CYC(WD_L),
		.DG_SHORT_CYC(DG_S), .DG_LONG_CYC(DG_L), .SOFT_CYC(SOFT), .BLANK_CYC(2)) i_chg_ctrl (.clk_sys(clk_sys),
		.rst(rst), .smb_scl(smb_scl), .smb_sda_in(sda_line), .smb_sda_out(smb_sda_out),
		.smb_sda_oe_n(smb_sda_oe_n), .sense(sense), .drive(drive));
	chg_host i_chg_host (.clk_sys(clk_sys), .sda_line(sda_line), .smb_scl(smb_scl), .host_sda(host_sda));

	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		forever begin
			wait (got_q.size() > 0);
			checks_done++;
			if (got_q[0] !== exp_q[0]) begin
				mismatches++;
				$display("Error at %0t: expected %h, got %h", $time, exp_q[0], got_q[0]);
			end
			void'(got_q.pop_front());
			void'(exp_q.pop_front());
		end
	end

	task automatic end_sim();
		#1;
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#10;
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		i_chg_host.write_word(cmd, d, nack);
	endtask

	task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] e);
		i_chg_host.read_word(cmd, rd, nack);
		`CHK(e, rd)
	endtask

	task automatic wait_on(input chg_pkg::chg_drive_t m, input int lim, output int n);
		for (n = 0; n < lim && (drive & m) !== m; n++) begin
			cyc(1);
		end
		if (n == lim) begin
			mismatches++;
			end_sim();
		end
	endtask

	task automatic pulses(input logic hs, input int cnt, input int width);
		sense.hs_short_cmp = hs;
		sense.ls_short_cmp = ~hs;
		repeat (cnt) begin
			sense.hs_switch_on = hs;
			sense.ls_switch_on = ~hs;
			cyc(width);
			sense.hs_switch_on = 1'b0;
			sense.ls_switch_on = 1'b0;
			cyc(3);
		end
	endtask

	initial begin
		cyc(90000);
		mismatches++;
		end_sim();
	end

	initial begin
		sense = '0;
		sense.adet_above_0v6 = 1'b1;
		sense.tj_below_135 = 1'b1;
		{m_ag, m_ss, m_su} = '0;
		m_ag.adapter_good = 1'b1;
		m_ss.soft_start = 1'b1;
		m_su.charge_suspended = 1'b1;
		cyc(12);
		rst = 1'b0;
		cyc(2);
		rd_chk(8'h12, 16'hf902);
		rd_chk(8'h14, 16'h0000);
		rd_chk(8'h15, 16'h0000);
		rd_chk(8'h3f, 16'h1000);
		rd_chk(8'hfe, MAKER);
		rd_chk(8'hff, PART);
		w = 16'($random(seed));
		wr(8'h14, w);
		rd_chk(8'h14, w & 16'h1fc0);
		wr(8'h15, ~w);
		rd_chk(8'h15, ~w & 16'h7ff0);
		wr(8'h3f, w);
		rd_chk(8'h3f, w & 16'h1f80);
		wr(8'hff, w);
		`CHK(16'(nack), 16'h0)
		rd_chk(8'hff, PART);
		sense.adet_above_2v4 = 1'b1;
		wr(8'h12, 16'h0000);
		rd_chk(8'h12, 16'h0010);
		for (int i = 0; i < 16; i++) begin
			b = i[3:0];
			wr(8'h12, {5'h00, b, 1'b0, b[3], 5'h00});
			cyc(2);
			w = {11'h0, drive.current_monitor_output_charge_sel, drive.freq_raise, drive.freq_adjust_en, drive.hs_short_detect_en,
				drive.ls_thresh_high};
			`CHK({11'h0, b[3], b[3] & b[2], b[2], b[1], b[0]}, w)
		end
		// First edge after reset must ignore the long setting
		wr(8'h12, 16'h8000);
		sense.adapter_good_raw = 1'b1;
		wait_on(m_ag, 200, k);
		`CHK(16'(k >= DG_S && k <= DG_S + 3), 16'h1)
		wr(8'h12, 16'h8040);
		cyc(2);
		`CHK({14'h0, drive.adapter_switch_on, drive.battery_switch_on}, 16'h1)
		sense.learn_depleted = 1'b1;
		cyc(2);
		sense.learn_depleted = 1'b0;
		rd_chk(8'h12, 16'h8010);
		sense.adapter_good_raw = 1'b0;
		cyc(2);
		sense.adapter_good_raw = 1'b1;
		wait_on(m_ag, 200, k);
		`CHK(16'(k >= DG_L && k <= DG_L + 3), 16'h1)
		wr(8'h12, 16'h8100);
		pulses(1'b1, 10, 1);
		pulses(1'b1, 6, 4);
		`CHK(16'(drive.short_latched), 16'h0)
		pulses(1'b1, 1, 4);
		cyc(2);
		`CHK({12'h0, drive.short_latched, drive.adapter_switch_on, drive.reverse_block_switch_on, drive.battery_switch_on}, 16'h9)
		wr(8'h12, 16'h8100);
		cyc(2);
		`CHK(16'(drive.short_latched), 16'h1)
		sense.adet_above_0v6 = 1'b0;
		cyc(3);
		`CHK(16'(drive.short_latched), 16'h0)
		sense.adet_above_0v6 = 1'b1;
		wr(8'h12, 16'h8000);
		pulses(1'b1, 8, 4);
		`CHK(16'(drive.short_latched), 16'h0)
		pulses(1'b0, 7, 4);
		cyc(2);
		`CHK(16'(drive.short_latched), 16'h1)
		sense.supply_supply_undervoltage_lockout = 1'b1;
		cyc(3);
		`CHK(16'(drive.short_latched), 16'h0)
		i_chg_host.read_word(8'h12, rd, nack);
		`CHK(16'(nack), 16'h1)
		sense.supply_supply_undervoltage_lockout = 1'b0;
		cyc(2);
		sense.tj_above_155 = 1'b1;
		sense.tj_below_135 = 1'b0;
		cyc(3);
		`CHK({14'h0, drive.thermal_shutdown, drive.converter_on}, 16'h2)
		sense.tj_above_155 = 1'b0;
		cyc(20);
		`CHK(16'(drive.thermal_shutdown), 16'h1)
		sense.tj_below_135 = 1'b1;
		wait_on(m_ss, 10, k);
		cyc(SOFT + 4);
		`CHK(16'h1, {13'h0, drive.thermal_shutdown, drive.soft_start, drive.converter_on})
		for (int c = 1; c < 4; c++) begin
			wr(8'h12, 16'(c) << 13);
			wr(8'h14, 16'h0040);
			per = (c == 1) ? WD_S : (c == 2) ? WD_M : WD_L;
			cyc(per - 100);
			`CHK(16'(drive.charge_suspended), 16'h0)
			wait_on(m_su, 200, k);
			`CHK(16'h2, {14'h0, drive.charge_suspended, drive.converter_on})
			rd_chk(8'h14, 16'h0040);
			wr(8'h15, 16'h0100);
			cyc(2);
			`CHK(16'(drive.charge_suspended), 16'h0)
		end
		wr(8'h12, 16'h0000);
		cyc(WD_L + 100);
		`CHK(16'(drive.charge_suspended), 16'h0)
		end_sim();
	end
endmodule
